//--- verilog/pssc_map.vh
// Register map, field layout and timing constants of the PID set point controller
// Summary of operation
// - Error is scaled feedback against active set point; speed command reduces it.
// - Feedback comes from the voltage or current input per feedback select bit.
// - Feedback maps linearly: minimum signal to low scale, maximum to high scale.
// - Low scale above high scale gives a falling value for rising signal.
// - Direct action raises speed on falling feedback, lowers it on rising.
// - Reverse action inverts the correction direction.
// - Action select changes only correction sign, never the feedback scaling.
// - Set point from keypad, current input, voltage input or pot on voltage.
// - Analog set point active only while select contact closed, else keypad.
// - An input used for feedback is never accepted as set point source.
// - Integral term keeps changing output until steady-state error is zero.
// - Differential term follows rate of change of error, not its size.
// - Set point ramps from old to new value, same rate up and down.
// - Ramp time of zero applies set point changes immediately.
// - In closed loop the status field shows output frequency, not run.
// - Enter key cycles display: set point, percent load, feedback.
// - Entering set point or feedback display flashes a label first.
// - Proportional term is gain times error percent of span.
// - Integral rate is gain times error percent, percent speed per second.
// - Differential term is gain times error rate in percent per second.
// - Loop action off disables closed loop; open-loop speed is followed.
`ifndef PSSC_MAP_VH
`define PSSC_MAP_VH
`define PSSC_ADDR_W        8
`define PSSC_OFS_CTRL      8'h00
`define PSSC_OFS_KEYPAD    8'h04
`define PSSC_OFS_FB_LOW    8'h08
`define PSSC_OFS_FB_HIGH   8'h0C
`define PSSC_OFS_P_GAIN    8'h10
`define PSSC_OFS_I_GAIN    8'h14
`define PSSC_OFS_D_GAIN    8'h18
`define PSSC_OFS_RAMP      8'h1C
`define PSSC_OFS_SPEED     8'h20
`define PSSC_OFS_PV        8'h24
`define PSSC_OFS_SP        8'h28
`define PSSC_OFS_ERR       8'h2C
`define PSSC_CTRL_MODE_LSB 0
`define PSSC_CTRL_FB_BIT   2
`define PSSC_CTRL_SRC_LSB  3
`define PSSC_MODE_OFF      2'h0
`define PSSC_MODE_DIRECT   2'h1
`define PSSC_MODE_REVERSE  2'h2
`define PSSC_SRC_KEYPAD    2'h0
`define PSSC_SRC_CURRENT   2'h1
`define PSSC_SRC_VOLTAGE   2'h2
`define PSSC_SRC_POT       2'h3
`define PSSC_RST_CTRL      16'h0000
`define PSSC_RST_KEYPAD    16'h0000
`define PSSC_RST_FB_LOW    16'h0000
`define PSSC_RST_FB_HIGH   16'h0FFF
`define PSSC_RST_P_GAIN    16'h0100
`define PSSC_RST_I_GAIN    16'h0000
`define PSSC_RST_D_GAIN    16'h0000
`define PSSC_RST_RAMP      16'h0000
`define PSSC_FULL          12'hFFF
`define PSSC_CUR_4MA       12'h333
`define PSSC_GAIN_SHIFT    8
`define PSSC_INT_SHIFT     18
`define PSSC_CLK_HZ        100000000
`define PSSC_SAMPLE_HZ     1000
`define PSSC_SAMPLE_CYCLES (`PSSC_CLK_HZ / `PSSC_SAMPLE_HZ)
`define PSSC_LABEL_MS      1000
`define PSSC_LABEL_TICKS   (`PSSC_LABEL_MS * `PSSC_SAMPLE_HZ / 1000)
`define PSSC_DIV_STEPS     5'h1D
`define PSSC_RESP_OKAY     2'h0
`define PSSC_RESP_SLVERR   2'h2
`endif

//--- verilog/pssc_top.v
// PID set point speed controller with AXI4-Lite register access
`timescale 1ns/1ps
`include "pssc_map.vh"
module pssc_top #(
   parameter SAMPLE_CYCLES = `PSSC_SAMPLE_CYCLES
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [11:0] voltage_analog_input,
   input  wire [11:0] current_analog_input,
   input  wire        setpoint_select_contact,
   input  wire        enter_key,
   input  wire [11:0] open_loop_speed,
   input  wire [15:0] output_freq,
   input  wire [7:0]  load_percent,
   output reg  [11:0] speed_cmd,
   output reg         closed_loop,
   output reg         status_shows_freq,
   output reg  [15:0] status_value,
   output reg  [1:0]  display_select,
   output reg         display_label,
   output reg  [15:0] display_value
);
   localparam S_IDLE = 2'h0;
   localparam S_ERR  = 2'h1;
   localparam S_DIV  = 2'h2;
   localparam S_PID  = 2'h3;
   localparam [31:0] TICK_MAX = SAMPLE_CYCLES - 1;
   localparam [15:0] LABEL_T = `PSSC_LABEL_TICKS;
   localparam [9:0] SAMPLE_RATE = `PSSC_SAMPLE_HZ;
   localparam signed [31:0] ACC_MAX = 32'sh3FFC0000;

   reg  [15:0] ctrl;
   reg  [15:0] keypad_sp;
   reg  [15:0] feedback_low_scale;
   reg  [15:0] feedback_high_scale;
   reg  [15:0] p_gain;
   reg  [15:0] i_gain;
   reg  [15:0] d_gain;
   reg  [15:0] setpoint_ramp_time;
   reg  [7:0]  wr_addr;
   reg         aw_held;
   reg  [31:0] wr_data;
   reg  [3:0]  wr_strb;
   reg         w_held;
   reg  [31:0] tick_cnt;
   reg         tick;
   reg  [1:0]  state;
   reg  signed [15:0] pv;
   reg  signed [15:0] sp_int;
   reg  [15:0] ramp_cnt;
   reg         err_neg;
   reg  [15:0] dsor;
   reg  [16:0] drem;
   reg  [28:0] dquo;
   reg  [4:0]  dcnt;
   reg  signed [12:0] e_q;
   reg  signed [12:0] e_prev;
   reg  signed [31:0] acc;
   reg         enter_d;
   reg  [15:0] label_cnt;

   wire [1:0]  mode    = ctrl[`PSSC_CTRL_MODE_LSB +: 2];
   wire        fb_cur  = ctrl[`PSSC_CTRL_FB_BIT];
   wire [1:0]  sp_src  = ctrl[`PSSC_CTRL_SRC_LSB +: 2];
   wire        loop_on = (mode == `PSSC_MODE_DIRECT) || (mode == `PSSC_MODE_REVERSE);
   wire signed [16:0] span = $signed({feedback_high_scale[15], feedback_high_scale})
                           - $signed({feedback_low_scale[15], feedback_low_scale});
   wire [15:0] span_abs = span[16] ? (~span[15:0] + 16'h0001) : span[15:0];

   function [15:0] merge;
      input [15:0] old;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge = old;
         if (strb[0])
            merge[7:0] = data[7:0];
         if (strb[1])
            merge[15:8] = data[15:8];
      end
   endfunction

   // Linear map of a 0..full fraction onto low..high scale
   function signed [15:0] scale;
      input [11:0] frac;
      reg signed [30:0] prod;
      begin
         prod  = span * $signed({1'h0, frac});
         scale = feedback_low_scale + prod[27:12];
      end
   endfunction

   // Current input: 4 mA floor to 20 mA full scale
   wire [11:0] cur_off = (current_analog_input > `PSSC_CUR_4MA) ?
                         (current_analog_input - `PSSC_CUR_4MA) : 12'h000;
   wire [14:0] cur_x5  = {3'h0, cur_off} + {1'h0, cur_off, 2'h0};
   wire [12:0] cur_sc  = cur_x5[14:2];
   wire [11:0] cur_frac = cur_sc[12] ? `PSSC_FULL : cur_sc[11:0];
   wire [11:0] fb_frac = fb_cur ? cur_frac : voltage_analog_input;

   // Analog set point only with contact closed and input not used for feedback
   wire src_cur = (sp_src == `PSSC_SRC_CURRENT);
   wire src_ok  = setpoint_select_contact && (sp_src != `PSSC_SRC_KEYPAD)
                  && (src_cur ? !fb_cur : fb_cur);
   wire signed [15:0] sp_target = src_ok ?
                      scale(src_cur ? cur_frac : voltage_analog_input) :
                      $signed(keypad_sp);

   // Error sign chosen by action; scaling untouched
   wire signed [16:0] err_raw = (mode == `PSSC_MODE_REVERSE) ?
                      ({pv[15], pv} - {sp_int[15], sp_int}) :
                      ({sp_int[15], sp_int} - {pv[15], pv});
   wire [16:0] err_abs = err_raw[16] ? -err_raw : err_raw;

   wire [16:0] dshift = {drem[15:0], dquo[28]};
   wire        dfit   = dshift >= {1'h0, dsor};

   // PID terms in 1/4096 of max speed
   wire signed [13:0] de    = {e_q[12], e_q} - {e_prev[12], e_prev};
   wire signed [30:0] p_trm = $signed({1'h0, p_gain}) * e_q;
   wire signed [30:0] i_inc = $signed({1'h0, i_gain}) * e_q;
   wire signed [41:0] d_trm = $signed({1'h0, d_gain}) * de
                            * $signed({1'h0, SAMPLE_RATE});
   wire signed [32:0] acc_n = {acc[31], acc} + {{2{i_inc[30]}}, i_inc};
   wire signed [31:0] acc_c = acc_n[32] ? 32'sh0 :
                              (acc_n > ACC_MAX) ? ACC_MAX : acc_n[31:0];
   wire signed [41:0] sum   = (p_trm >>> `PSSC_GAIN_SHIFT)
                            + (acc_c >>> `PSSC_INT_SHIFT)
                            + (d_trm >>> `PSSC_GAIN_SHIFT);
   wire [11:0] sum_c = sum[41] ? 12'h000 :
                       (sum > 42'sd4095) ? `PSSC_FULL : sum[11:0];

   // Register write side
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'h0;
         s_axi_wready  <= 1'h0;
         s_axi_bvalid  <= 1'h0;
         s_axi_bresp   <= `PSSC_RESP_OKAY;
         aw_held       <= 1'h0;
         w_held        <= 1'h0;
         wr_addr       <= 8'h00;
         wr_data       <= 32'h00000000;
         wr_strb       <= 4'h0;
         ctrl          <= `PSSC_RST_CTRL;
         keypad_sp     <= `PSSC_RST_KEYPAD;
         feedback_low_scale  <= `PSSC_RST_FB_LOW;
         feedback_high_scale <= `PSSC_RST_FB_HIGH;
         p_gain        <= `PSSC_RST_P_GAIN;
         i_gain        <= `PSSC_RST_I_GAIN;
         d_gain        <= `PSSC_RST_D_GAIN;
         setpoint_ramp_time <= `PSSC_RST_RAMP;
      end else begin
         s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'h1;
            wr_addr <= s_axi_awaddr;
            s_axi_awready <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'h1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
            s_axi_wready <= 1'h0;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held      <= 1'h0;
            w_held       <= 1'h0;
            s_axi_bvalid <= 1'h1;
            s_axi_bresp  <= `PSSC_RESP_OKAY;
            case ({wr_addr[7:2], 2'h0})
               `PSSC_OFS_CTRL:    ctrl <= merge(ctrl, wr_data, wr_strb);
               `PSSC_OFS_KEYPAD:  keypad_sp <= merge(keypad_sp, wr_data, wr_strb);
               `PSSC_OFS_FB_LOW:  feedback_low_scale <=
                                     merge(feedback_low_scale, wr_data, wr_strb);
               `PSSC_OFS_FB_HIGH: feedback_high_scale <=
                                     merge(feedback_high_scale, wr_data, wr_strb);
               `PSSC_OFS_P_GAIN:  p_gain <= merge(p_gain, wr_data, wr_strb);
               `PSSC_OFS_I_GAIN:  i_gain <= merge(i_gain, wr_data, wr_strb);
               `PSSC_OFS_D_GAIN:  d_gain <= merge(d_gain, wr_data, wr_strb);
               `PSSC_OFS_RAMP:    setpoint_ramp_time <=
                                     merge(setpoint_ramp_time, wr_data, wr_strb);
               `PSSC_OFS_SPEED, `PSSC_OFS_PV, `PSSC_OFS_SP, `PSSC_OFS_ERR:
                  s_axi_bresp <= `PSSC_RESP_OKAY;
               default:
                  s_axi_bresp <= `PSSC_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'h0;
      end
   end

   // Register read side
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid  <= 1'h0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `PSSC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'h0;
            s_axi_rvalid  <= 1'h1;
            s_axi_rresp   <= `PSSC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'h0})
               `PSSC_OFS_CTRL:    s_axi_rdata <= {16'h0000, ctrl};
               `PSSC_OFS_KEYPAD:  s_axi_rdata <= {16'h0000, keypad_sp};
               `PSSC_OFS_FB_LOW:  s_axi_rdata <= {16'h0000, feedback_low_scale};
               `PSSC_OFS_FB_HIGH: s_axi_rdata <= {16'h0000, feedback_high_scale};
               `PSSC_OFS_P_GAIN:  s_axi_rdata <= {16'h0000, p_gain};
               `PSSC_OFS_I_GAIN:  s_axi_rdata <= {16'h0000, i_gain};
               `PSSC_OFS_D_GAIN:  s_axi_rdata <= {16'h0000, d_gain};
               `PSSC_OFS_RAMP:    s_axi_rdata <= {16'h0000, setpoint_ramp_time};
               `PSSC_OFS_SPEED:   s_axi_rdata <= {20'h00000, speed_cmd};
               `PSSC_OFS_PV:      s_axi_rdata <= {16'h0000, pv};
               `PSSC_OFS_SP:      s_axi_rdata <= {16'h0000, sp_int};
               `PSSC_OFS_ERR:     s_axi_rdata <= {{19{e_q[12]}}, e_q};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `PSSC_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'h0;
      end
   end

   // Sample rate enable
   always @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt <= 32'h00000000;
         tick     <= 1'h0;
      end else begin
         tick     <= (tick_cnt == TICK_MAX);
         tick_cnt <= (tick_cnt == TICK_MAX) ? 32'h00000000 : tick_cnt + 32'h00000001;
      end
   end

   // Loop sequencer: scale and ramp, divide error by span, update terms
   always @(posedge aclk) begin
      if (!aresetn) begin
         state     <= S_IDLE;
         pv        <= 16'h0000;
         sp_int    <= 16'h0000;
         ramp_cnt  <= 16'h0000;
         err_neg   <= 1'h0;
         dsor      <= 16'h0000;
         drem      <= 17'h00000;
         dquo      <= 29'h00000000;
         dcnt      <= 5'h00;
         e_q       <= 13'h0000;
         e_prev    <= 13'h0000;
         acc       <= 32'h00000000;
         speed_cmd <= 12'h000;
      end else begin
         case (state)
            S_IDLE: begin
               if (tick) begin
                  pv    <= scale(fb_frac);
                  state <= S_ERR;
                  if (setpoint_ramp_time == 16'h0000) begin
                     sp_int   <= sp_target;
                     ramp_cnt <= 16'h0000;
                  end else if (ramp_cnt >= setpoint_ramp_time - 16'h0001) begin
                     ramp_cnt <= 16'h0000;
                     if (sp_int < sp_target)
                        sp_int <= sp_int + 16'sh0001;
                     else if (sp_int > sp_target)
                        sp_int <= sp_int - 16'sh0001;
                  end else begin
                     ramp_cnt <= ramp_cnt + 16'h0001;
                  end
               end
            end
            S_ERR: begin
               err_neg <= err_raw[16];
               dsor    <= span_abs;
               drem    <= 17'h00000;
               dquo    <= {err_abs, 12'h000};
               dcnt    <= `PSSC_DIV_STEPS;
               state   <= S_DIV;
            end
            S_DIV: begin
               drem  <= dfit ? (dshift - {1'h0, dsor}) : dshift;
               dquo  <= {dquo[27:0], dfit};
               dcnt  <= dcnt - 5'h01;
               if (dcnt == 5'h01)
                  state <= S_PID;
            end
            S_PID: begin
               // Error in 1/4096 of span, clipped at full span
               if (dsor == 16'h0000)
                  e_q <= 13'h0000;
               else if (dquo > 29'h00000FFF)
                  e_q <= err_neg ? -13'sh0FFF : 13'sh0FFF;
               else
                  e_q <= err_neg ? -$signed({1'h0, dquo[11:0]}) :
                                   $signed({1'h0, dquo[11:0]});
               state <= S_IDLE;
            end
            default:
               state <= S_IDLE;
         endcase
         if (!loop_on) begin
            acc       <= 32'h00000000;
            e_prev    <= 13'h0000;
            speed_cmd <= open_loop_speed;
         end else if (state == S_IDLE && tick) begin
            acc       <= acc_c;
            e_prev    <= e_q;
            speed_cmd <= sum_c;
         end
      end
   end

   // Operator display sequencing
   always @(posedge aclk) begin
      if (!aresetn) begin
         enter_d           <= 1'h0;
         display_select    <= 2'h0;
         label_cnt         <= 16'h0000;
         display_label     <= 1'h0;
         display_value     <= 16'h0000;
         closed_loop       <= 1'h0;
         status_shows_freq <= 1'h0;
         status_value      <= 16'h0000;
      end else begin
         enter_d <= enter_key;
         if (enter_key && !enter_d) begin
            display_select <= (display_select == 2'h2) ? 2'h0 : display_select + 2'h1;
            if (display_select != 2'h0)
               label_cnt <= LABEL_T;
         end else if (tick && label_cnt != 16'h0000) begin
            label_cnt <= label_cnt - 16'h0001;
         end
         display_label <= (label_cnt != 16'h0000);
         if (label_cnt != 16'h0000)
            display_value <= 16'h0000;
         else if (display_select == 2'h0)
            display_value <= sp_int;
         else if (display_select == 2'h1)
            display_value <= {8'h00, load_percent};
         else
            display_value <= pv;
         closed_loop       <= loop_on;
         status_shows_freq <= loop_on;
         status_value      <= loop_on ? output_freq : 16'h0000;
      end
   end
endmodule

//--- tb/pssc_monitor.sv
// Concurrent checks on the controller's top ports
`timescale 1ns/1ps
module pssc_monitor (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        closed_loop,
   input wire        status_shows_freq,
   input wire [15:0] status_value,
   input wire [15:0] output_freq,
   input wire        enter_key,
   input wire [1:0]  display_select,
   input wire        display_label,
   input wire [15:0] display_value
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   reg [1:0] sel_target;
   // Slot expected after an enter press
   always @(posedge aclk) begin
      if ($rose(enter_key))
         sel_target <= (display_select == 2'h2) ? 2'h0 : display_select + 2'h1;
   end
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WR_RESP: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   AST_RD_RESP: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read response missing");
   AST_RD_UNMAPPED: assert property (rd_taken ##0 (s_axi_araddr >= 8'h30)
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
   AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
   AST_SEL_RANGE: assert property (display_select != 2'h3)
      else $error("display slot out of range");
   AST_SEL_STEP: assert property ($rose(enter_key) |=> ##[0:3] display_select == sel_target)
      else $error("display slot order");
   AST_LABEL_FB: assert property ($changed(display_select) && display_select == 2'h2
      |-> ##[0:2] display_label) else $error("feedback label missing");
   AST_LABEL_VAL: assert property (display_label |-> display_value == 16'h0)
      else $error("value shown under label");
   AST_STATUS_FLAG: assert property (status_shows_freq == closed_loop
      && (closed_loop || status_value == 16'h0))
      else $error("status flag wrong");
   AST_STATUS_VAL: assert property (closed_loop && $past(closed_loop) &&
      $stable(output_freq) |-> status_value == output_freq) else $error("status value");
endmodule
bind pssc_top pssc_monitor u_pssc_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .closed_loop, .status_shows_freq,
   .status_value, .output_freq, .enter_key, .display_select, .display_label, .display_value);

//--- tb/pssc_transducer.sv
// Transducer model: process fractions to 0-10 V and 4-20 mA codes
`timescale 1ns/1ps
module pssc_transducer (
   input  wire        aclk,
   input  wire [11:0] volt_frac,
   input  wire [11:0] cur_frac,
   output reg  [11:0] voltage_analog_input = 12'h0,
   output reg  [11:0] current_analog_input = 12'h333
);
   always @(posedge aclk) begin
      voltage_analog_input <= volt_frac;
      current_analog_input <= 12'h333 + 12'(({12'h0, cur_frac} * 24'hCCC) / 24'hFFF);
   end
endmodule

//--- tb/tb_pid_setpoint_speed_control.sv
// Self-checking bench for the PID set point speed controller
`timescale 1ns/1ps
module tb_pid_setpoint_speed_control;
   localparam int SC = 64;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_rready, setpoint_select_contact, enter_key;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, load_percent;
   logic [31:0] s_axi_wdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [11:0] volt_frac, cur_frac, open_loop_speed, s1;
   logic [15:0] output_freq;
   logic [1:0]  rsp;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp, display_select;
   wire  [31:0] s_axi_rdata;
   wire  [11:0] voltage_analog_input, current_analog_input, speed_cmd;
   wire         closed_loop, status_shows_freq, display_label;
   wire  [15:0] status_value, display_value;
   int          err_total, check_count, lo, hi, kp, sp, pv, e;
   pssc_top #(.SAMPLE_CYCLES(SC)) u_pssc_top (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .voltage_analog_input,
      .current_analog_input, .setpoint_select_contact, .enter_key, .open_loop_speed,
      .output_freq, .load_percent, .speed_cmd, .closed_loop, .status_shows_freq,
      .status_value, .display_select, .display_label, .display_value);
   pssc_transducer u_pssc_transducer (.aclk, .volt_frac, .cur_frac, .voltage_analog_input,
      .current_analog_input);
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic near(input logic [15:0] got, input int exp);
      int d;
      check_count++;
      d = int'($signed(got)) - exp;
      if ($isunknown(got) || d > 8 || d < -8) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp[15:0]);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
   endtask
   task automatic rdr(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic ws(input int n);
      repeat (n * SC) @(posedge aclk);
   endtask
   task automatic press;
      enter_key <= 1'b1;
      repeat (3) @(posedge aclk);
      enter_key <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask
   // Proportional only, keypad set point, voltage feedback
   task automatic p_case(input logic [1:0] mode, input logic [11:0] sig);
      volt_frac <= sig;
      wr(8'h00, {30'h0, mode});
      ws(4);
      pv = lo + (hi - lo) * int'(sig) / 4095;
      e = (sp - pv) * 4096 / (hi > lo ? hi - lo : lo - hi) * kp / 256;
      if (mode == 2'h2) e = -e;
      rdr(8'h24);
      near(rd[15:0], pv);
      near({4'h0, speed_cmd}, e < 0 ? 0 : (e > 4095 ? 4095 : e));
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge aclk);
      err_total++;
      stop_test();
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h4;
      {aresetn, setpoint_select_contact, enter_key, s_axi_awaddr, s_axi_araddr} = 19'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      {volt_frac, cur_frac} = 24'h0;
      err_total = 0;
      check_count = 0;
      rd = $urandom(13966);
      load_percent = 8'($urandom);
      output_freq = 16'($urandom);
      open_loop_speed = 12'($urandom);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      for (int i = 0; i < 4; i++) begin
         rdr(8'(i * 4 + (i > 0 ? 4 : 0)));
         chk(rd, i == 2 ? 32'h0FFF : (i == 3 ? 32'h0100 : 32'h0));
      end
      rdr(8'h40);
      chk({rd, rsp}, {32'h0, 2'h2});
      wr(8'h44, 32'h1234);
      chk(rsp, 2'h2);
      wr(8'h20, 32'h0ABC);
      chk(rsp, 2'h0);
      $display("test registers done");
      ws(3);
      chk(speed_cmd, open_loop_speed);
      chk({closed_loop, status_value}, 17'h0);
      $display("test loop off done");
      lo = 0;
      hi = 4095;
      kp = 256;
      sp = 2048;
      wr(8'h04, 32'h0800);
      repeat (3) begin
         s1 = 12'($urandom_range(32'h100, 32'hEFF));
         p_case(2'h1, s1);
         p_case(2'h2, s1);
      end
      chk({status_shows_freq, status_value}, {1'b1, output_freq});
      wr(8'h08, 32'h0FFF);
      wr(8'h0C, 32'h0);
      lo = 4095;
      hi = 0;
      p_case(2'h1, 12'hA00);
      p_case(2'h2, 12'h600);
      wr(8'h08, 32'h0);
      wr(8'h0C, 32'h0FFF);
      cur_frac <= 12'h400;
      wr(8'h00, 32'h5);
      ws(4);
      rdr(8'h24);
      near(rd[15:0], 12'h400);
      $display("test proportional done");
      cur_frac <= 12'h300;
      volt_frac <= 12'h500;
      for (int s = 1; s < 4; s++) begin
         setpoint_select_contact <= 1'b1;
         wr(8'h00, 32'(1 + (s == 1 ? 0 : 4) + s * 8));
         ws(3);
         rdr(8'h28);
         near(rd[15:0], s == 1 ? 12'h300 : 12'h500);
      end
      setpoint_select_contact <= 1'b0;
      ws(3);
      rdr(8'h28);
      near(rd[15:0], 12'h800);
      setpoint_select_contact <= 1'b1;
      wr(8'h00, 32'h11);
      ws(3);
      rdr(8'h28);
      near(rd[15:0], 12'h800);
      $display("test sources done");
      wr(8'h00, 32'h1);
      wr(8'h1C, 32'h1);
      wr(8'h04, 32'h0840);
      ws(16);
      rdr(8'h28);
      near(rd[15:0], 12'h810);
      ws(60);
      wr(8'h04, 32'h0800);
      ws(16);
      rdr(8'h28);
      near(rd[15:0], 12'h830);
      wr(8'h1C, 32'h0);
      wr(8'h04, 32'h0900);
      ws(2);
      rdr(8'h28);
      near(rd[15:0], 12'h900);
      $display("test ramp done");
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h1000);
      wr(8'h04, 32'h0C00);
      volt_frac <= 12'h400;
      ws(3);
      rdr(8'h2C);
      near(rd[15:0], 12'h800);
      s1 = speed_cmd;
      ws(8);
      chk({31'h0, speed_cmd > s1}, 32'h1);
      ws(140);
      chk(speed_cmd, 12'hFFF);
      volt_frac <= 12'hFFF;
      ws(270);
      chk(speed_cmd, 12'h0);
      wr(8'h00, 32'h0);
      wr(8'h14, 32'h0);
      wr(8'h18, 32'h0100);
      wr(8'h00, 32'h1);
      volt_frac <= 12'h400;
      ws(6);
      near({4'h0, speed_cmd}, 0);
      $display("test integral done");
      press();
      chk({display_select, display_label, display_value}, {3'h2, 8'h0, load_percent});
      press();
      chk({display_select, display_label, display_value}, {3'h5, 16'h0});
      press();
      chk({display_select, display_label}, 3'h1);
      $display("test display done");
      stop_test();
   end
endmodule
